// >>> design/tsm_pkg.sv
// Shared constants and types of the contactless tag state machine.
package tsm_pkg;

    // Tag states, one-hot.
    typedef enum logic [5:0] {
        ST_OFF    = 6'h01,
        ST_IDLE   = 6'h02,
        ST_READY1 = 6'h04,
        ST_READY2 = 6'h08,
        ST_ACTIVE = 6'h10,
        ST_HALT   = 6'h20
    } tsm_state_t;

    // Classes of received commands.
    typedef enum logic [3:0] {
        CMD_OTHER  = 4'h0,
        CMD_REQA   = 4'h1,
        CMD_WUPA   = 4'h2,
        CMD_AC1    = 4'h3,
        CMD_SEL1   = 4'h4,
        CMD_AC2    = 4'h5,
        CMD_SEL2   = 4'h6,
        CMD_HLTA   = 4'h7,
        CMD_READ   = 4'h8,
        CMD_FREAD  = 4'h9,
        CMD_WRITE  = 4'ha,
        CMD_LWRITE = 4'hb,
        CMD_VER    = 4'hc
    } tsm_cmd_t;

    // Kinds of reply produced by the state machine itself.
    typedef enum logic [1:0] {
        RSP_ATQA = 2'h0,
        RSP_SAK  = 2'h1,
        RSP_NAK  = 2'h2
    } tsm_rsp_t;

    // Command codes and parameter bytes.
    localparam logic [7:0] CODE_REQA   = 8'h26;
    localparam logic [7:0] CODE_WUPA   = 8'h52;
    localparam logic [7:0] CODE_CASC1  = 8'h93;
    localparam logic [7:0] CODE_CASC2  = 8'h95;
    localparam logic [7:0] CODE_HLTA   = 8'h50;
    localparam logic [7:0] CODE_READ   = 8'h30;
    localparam logic [7:0] CODE_FREAD  = 8'h3a;
    localparam logic [7:0] CODE_WRITE  = 8'ha2;
    localparam logic [7:0] CODE_LWRITE = 8'ha0;
    localparam logic [7:0] CODE_VER    = 8'h60;
    localparam logic [7:0] PAR_SELECT  = 8'h70;
    localparam logic [7:0] PAR_AC_LO   = 8'h20;
    localparam logic [7:0] PAR_AC_HI   = 8'h67;
    localparam logic [7:0] PAR_HLTA    = 8'h00;

    // Page limits and reply values.
    localparam logic [7:0]  PAGE_READY_MAX = 8'h0f;
    localparam logic [7:0]  PAGE_MAX       = 8'h4f;
    localparam logic [15:0] ATQA_VALUE     = 16'h0044;
    localparam logic [7:0]  SAK_CL1        = 8'h04;
    localparam logic [7:0]  SAK_CL2        = 8'h00;
    localparam logic [3:0]  NAK_INVALID    = 4'h0;
    localparam logic [4:0]  LEN_ATQA       = 5'h10;
    localparam logic [4:0]  LEN_SAK        = 5'h08;
    localparam logic [4:0]  LEN_NAK        = 5'h04;

endpackage : tsm_pkg

// >>> design/tsm_sync.sv
// Two-flop synchroniser for one asynchronous level.
`timescale 1ns/10ps
`default_nettype none
module tsm_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Level
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic meta_q;
    logic sync_q;

    // The first flop feeds only the second, so a metastable value never fans out.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
        end
    end

    assign syncOut = sync_q;

endmodule : tsm_sync
`default_nettype wire

// >>> design/tsm_cmd_decode.sv
// Classifier that turns a received command frame into a command class.
`timescale 1ns/10ps
`default_nettype none
module tsm_cmd_decode (
    // Received frame
    input  wire logic [7:0]        cmdCode,
    input  wire logic [7:0]        cmdParam,
    input  wire logic              cmdShort,
    // Class
    output var tsm_pkg::tsm_cmd_t  cmdClass
);
    logic acParam;

    assign acParam = (cmdParam >= tsm_pkg::PAR_AC_LO) && (cmdParam <= tsm_pkg::PAR_AC_HI);

    always_comb begin
        cmdClass = tsm_pkg::CMD_OTHER;
        if (cmdShort) begin
            if (cmdCode == tsm_pkg::CODE_REQA) begin
                cmdClass = tsm_pkg::CMD_REQA;
            end else if (cmdCode == tsm_pkg::CODE_WUPA) begin
                cmdClass = tsm_pkg::CMD_WUPA;
            end
        end else begin
            case (cmdCode)
                tsm_pkg::CODE_CASC1: begin
                    if (cmdParam == tsm_pkg::PAR_SELECT) begin
                        cmdClass = tsm_pkg::CMD_SEL1;
                    end else if (acParam) begin
                        cmdClass = tsm_pkg::CMD_AC1;
                    end
                end
                tsm_pkg::CODE_CASC2: begin
                    if (cmdParam == tsm_pkg::PAR_SELECT) begin
                        cmdClass = tsm_pkg::CMD_SEL2;
                    end else if (acParam) begin
                        cmdClass = tsm_pkg::CMD_AC2;
                    end
                end
                tsm_pkg::CODE_HLTA: begin
                    if (cmdParam == tsm_pkg::PAR_HLTA) begin
                        cmdClass = tsm_pkg::CMD_HLTA;
                    end
                end
                tsm_pkg::CODE_READ:   cmdClass = tsm_pkg::CMD_READ;
                tsm_pkg::CODE_FREAD:  cmdClass = tsm_pkg::CMD_FREAD;
                tsm_pkg::CODE_WRITE:  cmdClass = tsm_pkg::CMD_WRITE;
                tsm_pkg::CODE_LWRITE: cmdClass = tsm_pkg::CMD_LWRITE;
                tsm_pkg::CODE_VER:    cmdClass = tsm_pkg::CMD_VER;
                default:              cmdClass = tsm_pkg::CMD_OTHER;
            endcase
        end
    end

endmodule : tsm_cmd_decode
`default_nettype wire

// >>> design/tsm_tag_fsm.sv
// Command-driven state machine of a contactless Type A tag.
`timescale 1ns/10ps
`default_nettype none
module tsm_tag_fsm (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Enables
    input  wire logic                 tagFunctionEnable,
    input  wire logic                 fieldPresentFlag,
    // Command from frame receiver
    input  wire logic                 cmdValid,
    input  wire logic                 cmdShort,
    input  wire logic [7:0]           cmdCode,
    input  wire logic [7:0]           cmdParam,
    input  wire logic                 parityErr,
    input  wire logic                 crcErr,
    input  wire logic                 uidMatch,
    input  wire logic                 uidCollided,
    // Memory datapath status
    input  wire logic                 memNak,
    // Reply to the reader
    output logic                      rspValid,
    output var tsm_pkg::tsm_rsp_t     rspKind,
    output logic [15:0]               rspData,
    output logic [4:0]                rspBits,
    // Requests to datapaths
    output logic                      readReq,
    output logic [7:0]                readPage,
    output logic                      anticollReq,
    output logic                      anticollLevel2,
    output logic [7:0]                anticollParam,
    output logic                      memCmdValid,
    output logic [7:0]                memCmdCode,
    // Status
    output var tsm_pkg::tsm_state_t   tagState,
    output logic                      fromHalt,
    output logic                      cmdError
);
    logic                fieldSync;
    logic                run;
    tsm_pkg::tsm_cmd_t   cmdClass;
    tsm_pkg::tsm_state_t state_q;
    tsm_pkg::tsm_state_t state_d;
    tsm_pkg::tsm_state_t restState;
    tsm_pkg::tsm_cmd_t   selHere;
    tsm_pkg::tsm_cmd_t   acHere;
    logic                fromHalt_q;
    logic                fromHalt_d;
    logic                sayAtqa;
    logic                saySak1;
    logic                saySak2;
    logic                sayNak;
    logic                doRead;
    logic                doAnticoll;
    logic                doMem;
    logic                isError;

    // The field flag comes from the analogue detector; the enable bit is on this clock.
    tsm_sync u_fieldSync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn (fieldPresentFlag),
        .syncOut (fieldSync)
    );

    tsm_cmd_decode u_decode (
        .cmdCode  (cmdCode),
        .cmdParam (cmdParam),
        .cmdShort (cmdShort),
        .cmdClass (cmdClass)
    );

    assign run       = tagFunctionEnable && fieldSync;
    assign restState = fromHalt_q ? tsm_pkg::ST_HALT : tsm_pkg::ST_IDLE;
    assign selHere   = (state_q == tsm_pkg::ST_READY2) ? tsm_pkg::CMD_SEL2 : tsm_pkg::CMD_SEL1;
    assign acHere    = (state_q == tsm_pkg::ST_READY2) ? tsm_pkg::CMD_AC2 : tsm_pkg::CMD_AC1;

    // Next state and the actions of the command being taken.
    always_comb begin
        state_d    = state_q;
        sayAtqa    = 1'b0;
        saySak1    = 1'b0;
        saySak2    = 1'b0;
        sayNak     = 1'b0;
        doRead     = 1'b0;
        doAnticoll = 1'b0;
        doMem      = 1'b0;
        isError    = 1'b0;
        if (!run) begin
            state_d = tsm_pkg::ST_OFF;
        end else if (state_q == tsm_pkg::ST_OFF) begin
            state_d = tsm_pkg::ST_IDLE;
        end else if (memNak && (state_q == tsm_pkg::ST_ACTIVE)) begin
            // The datapath has already sent its NAK; a command in the same cycle is dropped.
            state_d = restState;
        end else if (cmdValid) begin
            case (state_q)
                tsm_pkg::ST_IDLE: begin
                    if ((cmdClass == tsm_pkg::CMD_REQA) || (cmdClass == tsm_pkg::CMD_WUPA)) begin
                        state_d = tsm_pkg::ST_READY1;
                        sayAtqa = 1'b1;
                    end else begin
                        isError = 1'b1;
                    end
                end
                tsm_pkg::ST_HALT: begin
                    if (cmdClass == tsm_pkg::CMD_WUPA) begin
                        state_d = tsm_pkg::ST_READY1;
                        sayAtqa = 1'b1;
                    end else begin
                        isError = 1'b1;
                    end
                end
                tsm_pkg::ST_READY1, tsm_pkg::ST_READY2: begin
                    if (cmdClass == tsm_pkg::CMD_READ) begin
                        if (cmdParam <= tsm_pkg::PAGE_READY_MAX) begin
                            doRead  = 1'b1;
                            state_d = tsm_pkg::ST_ACTIVE;
                        end else begin
                            isError = 1'b1;
                            sayNak  = cmdParam > tsm_pkg::PAGE_MAX;
                            state_d = restState;
                        end
                    end else if (cmdClass == selHere) begin
                        if (parityErr) begin
                            state_d = restState;
                        end else if (uidMatch) begin
                            // A select for another tag is simply not answered.
                            saySak1 = state_q == tsm_pkg::ST_READY1;
                            saySak2 = state_q == tsm_pkg::ST_READY2;
                            state_d = (state_q == tsm_pkg::ST_READY1) ? tsm_pkg::ST_READY2
                                                                       : tsm_pkg::ST_ACTIVE;
                        end
                    end else if (cmdClass == acHere) begin
                        if (uidCollided) begin
                            state_d = restState;
                        end else begin
                            doAnticoll = 1'b1;
                        end
                    end else begin
                        isError = 1'b1;
                        state_d = restState;
                    end
                end
                tsm_pkg::ST_ACTIVE: begin
                    case (cmdClass)
                        tsm_pkg::CMD_READ: begin
                            if (cmdParam <= tsm_pkg::PAGE_MAX) begin
                                doRead = 1'b1;
                            end else begin
                                sayNak  = 1'b1;
                                state_d = restState;
                            end
                        end
                        tsm_pkg::CMD_FREAD, tsm_pkg::CMD_WRITE,
                        tsm_pkg::CMD_LWRITE, tsm_pkg::CMD_VER: begin
                            doMem = 1'b1;
                        end
                        tsm_pkg::CMD_HLTA: begin
                            // Parity slips are tolerated on HLTA; only a CRC error refuses it.
                            if (crcErr) begin
                                sayNak  = 1'b1;
                                state_d = restState;
                            end else begin
                                state_d = tsm_pkg::ST_HALT;
                            end
                        end
                        default: begin
                            isError = 1'b1;
                            state_d = restState;
                        end
                    endcase
                end
                default: state_d = tsm_pkg::ST_OFF;
            endcase
        end
    end

    // Origin flag: set on entering HALT, cleared on IDLE or OFF.
    always_comb begin
        fromHalt_d = fromHalt_q;
        if (state_d == tsm_pkg::ST_HALT) begin
            fromHalt_d = 1'b1;
        end else if ((state_d == tsm_pkg::ST_IDLE) || (state_d == tsm_pkg::ST_OFF)) begin
            fromHalt_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q    <= tsm_pkg::ST_OFF;
            fromHalt_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            fromHalt_q <= fromHalt_d;
        end
    end

    // Replies produced by the state machine itself.
    always_ff @(posedge clk) begin
        if (rst) begin
            rspValid <= 1'b0;
            rspKind  <= tsm_pkg::RSP_ATQA;
            rspData  <= 16'h0000;
            rspBits  <= 5'h00;
        end else begin
            rspValid <= sayAtqa || saySak1 || saySak2 || sayNak;
            if (sayAtqa) begin
                rspKind <= tsm_pkg::RSP_ATQA;
                rspData <= tsm_pkg::ATQA_VALUE;
                rspBits <= tsm_pkg::LEN_ATQA;
            end else if (saySak1 || saySak2) begin
                rspKind <= tsm_pkg::RSP_SAK;
                rspData <= {8'h00, saySak1 ? tsm_pkg::SAK_CL1 : tsm_pkg::SAK_CL2};
                rspBits <= tsm_pkg::LEN_SAK;
            end else if (sayNak) begin
                rspKind <= tsm_pkg::RSP_NAK;
                rspData <= {12'h000, tsm_pkg::NAK_INVALID};
                rspBits <= tsm_pkg::LEN_NAK;
            end
        end
    end

    // Requests handed to the memory and UID datapaths.
    always_ff @(posedge clk) begin
        if (rst) begin
            readReq        <= 1'b0;
            readPage       <= 8'h00;
            anticollReq    <= 1'b0;
            anticollLevel2 <= 1'b0;
            anticollParam  <= 8'h00;
            memCmdValid    <= 1'b0;
            memCmdCode     <= 8'h00;
            cmdError       <= 1'b0;
        end else begin
            readReq     <= doRead;
            anticollReq <= doAnticoll;
            memCmdValid <= doMem;
            cmdError    <= isError;
            if (doRead) begin
                readPage <= cmdParam;
            end
            if (doAnticoll) begin
                anticollLevel2 <= state_q == tsm_pkg::ST_READY2;
                anticollParam  <= cmdParam;
            end
            if (doMem) begin
                memCmdCode <= cmdCode;
            end
        end
    end

    assign tagState = state_q;
    assign fromHalt = fromHalt_q;

    // Checks of the state machine against its causes.
    default clocking cbMain @(posedge clk);
    endclocking
    default disable iff (rst);

    logic take;
    assign take = run && cmdValid && (state_q != tsm_pkg::ST_OFF)
                  && !(memNak && (state_q == tsm_pkg::ST_ACTIVE));

    chk_off_when_lost: assert property (
        !run |=> (tagState == tsm_pkg::ST_OFF) && !fromHalt)
        else $error("Tag not off after enable or field loss.");

    chk_enable_idle: assert property (
        run && (tagState == tsm_pkg::ST_OFF) |=> tagState == tsm_pkg::ST_IDLE)
        else $error("Tag did not enter idle when enabled.");

    chk_idle_wake: assert property (
        take && (tagState == tsm_pkg::ST_IDLE)
        && ((cmdClass == tsm_pkg::CMD_REQA) || (cmdClass == tsm_pkg::CMD_WUPA))
        |=> (tagState == tsm_pkg::ST_READY1) && rspValid && (rspData == 16'h0044)
            && (rspBits == 5'h10))
        else $error("Idle wake-up did not answer ATQA.");

    chk_idle_error: assert property (
        take && (tagState == tsm_pkg::ST_IDLE) && (cmdClass != tsm_pkg::CMD_REQA)
        && (cmdClass != tsm_pkg::CMD_WUPA) |=> (tagState == tsm_pkg::ST_IDLE) && cmdError)
        else $error("Idle left on an invalid command.");

    chk_halt_hold: assert property (
        take && (tagState == tsm_pkg::ST_HALT) && (cmdClass != tsm_pkg::CMD_WUPA)
        |=> (tagState == tsm_pkg::ST_HALT) && !rspValid)
        else $error("Halt left on a command other than WUPA.");

    chk_sel1_ack: assert property (
        take && (tagState == tsm_pkg::ST_READY1) && (cmdClass == tsm_pkg::CMD_SEL1)
        && !parityErr && uidMatch
        |=> (tagState == tsm_pkg::ST_READY2) && rspValid && (rspData == 16'h0004))
        else $error("Select CL1 not acknowledged with 04h.");

    chk_sel2_ack: assert property (
        take && (tagState == tsm_pkg::ST_READY2) && (cmdClass == tsm_pkg::CMD_SEL2)
        && !parityErr && uidMatch
        |=> (tagState == tsm_pkg::ST_ACTIVE) && rspValid && (rspData == 16'h0000))
        else $error("Select CL2 not acknowledged with 00h.");

    chk_sel_parity: assert property (
        take && parityErr && (cmdClass == selHere)
        && ((tagState == tsm_pkg::ST_READY1) || (tagState == tsm_pkg::ST_READY2))
        |=> !rspValid && (tagState == ($past(fromHalt) ? tsm_pkg::ST_HALT : tsm_pkg::ST_IDLE)))
        else $error("Select with parity error did not fall back silently.");

    chk_collide_drop: assert property (
        take && uidCollided && (cmdClass == acHere)
        && ((tagState == tsm_pkg::ST_READY1) || (tagState == tsm_pkg::ST_READY2))
        |=> (tagState == tsm_pkg::ST_IDLE) || (tagState == tsm_pkg::ST_HALT))
        else $error("Collided tag stayed in the procedure.");

    chk_ready_read: assert property (
        take && (cmdClass == tsm_pkg::CMD_READ) && (cmdParam <= 8'h0f)
        && ((tagState == tsm_pkg::ST_READY1) || (tagState == tsm_pkg::ST_READY2))
        |=> (tagState == tsm_pkg::ST_ACTIVE) && readReq && (readPage == $past(cmdParam)))
        else $error("Ready read did not serve and activate.");

    chk_nak_rest: assert property (
        rspValid && (rspKind == tsm_pkg::RSP_NAK) |-> (rspBits == 5'h04)
        && (tagState == (fromHalt ? tsm_pkg::ST_HALT : tsm_pkg::ST_IDLE)))
        else $error("NAK not followed by the rest state.");

    chk_hlta_halt: assert property (
        take && (tagState == tsm_pkg::ST_ACTIVE) && (cmdClass == tsm_pkg::CMD_HLTA) && !crcErr
        |=> (tagState == tsm_pkg::ST_HALT) && fromHalt)
        else $error("Clean HLTA did not halt.");

    chk_mem_active: assert property (
        memCmdValid |-> $past(tagState) == tsm_pkg::ST_ACTIVE)
        else $error("Memory command passed outside the active state.");

    chk_active_error: assert property (
        take && cmdError == 1'b0 && (tagState != tsm_pkg::ST_IDLE)
        && (tagState != tsm_pkg::ST_HALT) && (cmdClass == tsm_pkg::CMD_OTHER)
        |=> cmdError && (tagState == ($past(fromHalt) ? tsm_pkg::ST_HALT : tsm_pkg::ST_IDLE)))
        else $error("Invalid command did not fall back to rest.");

    cov_full_select: cover property (
        (tagState == tsm_pkg::ST_READY2) ##1 (tagState == tsm_pkg::ST_ACTIVE));
    cov_halt_wake: cover property (
        (tagState == tsm_pkg::ST_HALT) ##1 (tagState == tsm_pkg::ST_READY1));
    cov_ready_read: cover property (
        (tagState == tsm_pkg::ST_READY1) ##1 (tagState == tsm_pkg::ST_ACTIVE) && readReq);

endmodule : tsm_tag_fsm
`default_nettype wire

// >>> bench/tsm_reader.sv
// Reader model that presents one command frame per call.
`timescale 1ns/10ps
`default_nettype none
module tsm_reader (
    // Clock
    input  wire logic       clk,
    // Command frame
    output logic            cmdValid,
    output logic            cmdShort,
    output logic [7:0]      cmdCode,
    output logic [7:0]      cmdParam,
    output logic            parityErr,
    output logic            crcErr,
    output logic            uidCollided,
    output logic            uidMatch,
    // Memory datapath
    output logic            memNak
);
    initial begin
        {cmdValid, cmdShort, parityErr, crcErr, uidCollided} = 5'h00;
        {cmdCode, cmdParam} = 16'h0000;
        uidMatch = 1'b1;
        memNak = 1'b0;
    end
    // The match line only moves between frames, so it never changes under a taken select.
    task automatic set_uid(input logic m);
        @(negedge clk);
        uidMatch = m;
    endtask : set_uid
    task automatic pulse_nak;
        @(negedge clk);
        memNak = 1'b1;
        @(negedge clk);
        memNak = 1'b0;
    endtask : pulse_nak
    task automatic send(input logic [7:0] c, input logic [7:0] p, input logic [3:0] f);
        @(negedge clk);
        {cmdShort, parityErr, crcErr, uidCollided} = f;
        cmdCode = c;
        cmdParam = p;
        cmdValid = 1'b1;
        @(negedge clk);
        cmdValid = 1'b0;
        // Bytes are not held between frames, so a stale value can never pass.
        cmdCode = ~c;
        cmdParam = ~p;
    endtask : send
endmodule : tsm_reader
`default_nettype wire

// >>> bench/test_tsm_tag_fsm.sv
// Self-checking bench of the tag state machine.
`timescale 1ns/10ps
`default_nettype none
module test_tsm_tag_fsm;
    logic clk, rst, en, field, rspValid, readReq, fromHalt, cmdError;
    logic [15:0] rspData;
    logic [4:0] rspBits;
    logic [7:0] readPage;
    tsm_pkg::tsm_state_t tagState;
    logic acReq, acL2, memV;
    logic [7:0] acPar, memC;
    tsm_pkg::tsm_rsp_t rspKind;
    wire logic cV, cS, pE, cE, uC, uM, mN;
    wire logic [7:0] cC, cP;
    int n_fail = 0;
    int checks = 0;
    tsm_reader u_rdr (.clk(clk), .cmdValid(cV), .cmdShort(cS), .cmdCode(cC),
        .cmdParam(cP), .parityErr(pE), .crcErr(cE), .uidCollided(uC),
        .uidMatch(uM), .memNak(mN));
    tsm_tag_fsm u_dut (.clk(clk), .rst(rst), .tagFunctionEnable(en),
        .fieldPresentFlag(field), .cmdValid(cV), .cmdShort(cS), .cmdCode(cC),
        .cmdParam(cP), .parityErr(pE), .crcErr(cE), .uidMatch(uM),
        .uidCollided(uC), .memNak(mN), .rspValid(rspValid), .rspKind(rspKind),
        .rspData(rspData), .rspBits(rspBits), .readReq(readReq),
        .readPage(readPage), .anticollReq(acReq), .anticollLevel2(acL2),
        .anticollParam(acPar), .memCmdValid(memV), .memCmdCode(memC),
        .tagState(tagState), .fromHalt(fromHalt), .cmdError(cmdError));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic st(input tsm_pkg::tsm_state_t e);
        chk("state", 16'(tagState), 16'(e));
    endtask : st
    task automatic rsp(input logic [15:0] e);
        chk("reply", {rspValid, 13'h0000, rspKind}, e);
    endtask : rsp
    task automatic t_idle;
        u_rdr.send(8'h30, 8'h00, 4'h0);
        st(tsm_pkg::ST_IDLE);
        chk("err", 16'(cmdError), 16'h0001);
        u_rdr.send(8'h26, 8'h00, 4'h8);
        st(tsm_pkg::ST_READY1);
        chk("atqa", rspData, 16'h0044);
        chk("bits", 16'(rspBits), 16'h0010);
        rsp(16'h8000);
    endtask : t_idle
    task automatic t_select;
        u_rdr.send(8'h93, 8'h70, 4'h0);
        st(tsm_pkg::ST_READY2);
        chk("sak1", rspData, 16'h0004);
        rsp(16'h8001);
        u_rdr.send(8'h95, 8'h70, 4'h0);
        st(tsm_pkg::ST_ACTIVE);
        chk("sak2", rspData, 16'h0000);
    endtask : t_select
    task automatic t_halt;
        u_rdr.send(8'h50, 8'h00, 4'h0);
        st(tsm_pkg::ST_HALT);
        @(negedge clk);
        chk("halted", 16'(fromHalt), 16'h0001);
        u_rdr.send(8'h26, 8'h00, 4'h8);
        st(tsm_pkg::ST_HALT);
        u_rdr.send(8'h52, 8'h00, 4'h8);
        st(tsm_pkg::ST_READY1);
        u_rdr.send(8'h93, 8'h70, 4'h4);
        st(tsm_pkg::ST_HALT);
    endtask : t_halt
    task automatic t_read;
        u_rdr.send(8'h52, 8'h00, 4'h8);
        u_rdr.send(8'h30, 8'h0f, 4'h0);
        st(tsm_pkg::ST_ACTIVE);
        chk("page", {7'h00, readReq, readPage}, 16'h010f);
        u_rdr.send(8'h50, 8'h00, 4'h2);
        st(tsm_pkg::ST_HALT);
        u_rdr.send(8'h52, 8'h00, 4'h8);
        u_rdr.send(8'h30, 8'h50, 4'h0);
        st(tsm_pkg::ST_HALT);
        chk("nak", {rspData[3:0], 7'h00, rspBits}, 16'h0004);
        rsp(16'h8002);
    endtask : t_read
    task automatic t_lost;
        en = 1'b0;
        repeat (2) @(negedge clk);
        chk("off", {fromHalt, 9'h000, tagState}, 16'h0001);
        en = 1'b1;
        repeat (2) @(negedge clk);
        st(tsm_pkg::ST_IDLE);
    endtask : t_lost
    task automatic t_anticoll;
        u_rdr.send(8'h26, 8'h00, 4'h8);
        u_rdr.send(8'h93, 8'h20, 4'h0);
        st(tsm_pkg::ST_READY1);
        chk("ac1", {acReq, acL2, 6'h00, acPar}, 16'h8020);
        u_rdr.set_uid(1'b0);
        u_rdr.send(8'h93, 8'h70, 4'h0);
        st(tsm_pkg::ST_READY1);
        rsp(16'h0000);
        u_rdr.set_uid(1'b1);
        u_rdr.send(8'h93, 8'h70, 4'h0);
        st(tsm_pkg::ST_READY2);
        u_rdr.send(8'h95, 8'h25, 4'h0);
        chk("ac2", {acReq, acL2, 6'h00, acPar}, 16'hc025);
        u_rdr.send(8'h95, 8'h25, 4'h1);
        st(tsm_pkg::ST_IDLE);
        chk("acdrop", 16'(acReq), 16'h0000);
        u_rdr.send(8'h52, 8'h00, 4'h8);
        u_rdr.send(8'h93, 8'h70, 4'h0);
        u_rdr.send(8'h95, 8'h70, 4'h4);
        st(tsm_pkg::ST_IDLE);
        rsp(16'h0001);
        u_rdr.send(8'h26, 8'h00, 4'h8);
        u_rdr.send(8'h93, 8'h70, 4'h0);
        u_rdr.send(8'h30, 8'h04, 4'h0);
        st(tsm_pkg::ST_ACTIVE);
        chk("page2", {7'h00, readReq, readPage}, 16'h0104);
    endtask : t_anticoll
    task automatic t_active;
        u_rdr.send(8'ha2, 8'h04, 4'h0);
        chk("mem", {memV, 7'h00, memC}, 16'h80a2);
        u_rdr.send(8'h30, 8'h4f, 4'h0);
        st(tsm_pkg::ST_ACTIVE);
        chk("page3", {7'h00, readReq, readPage}, 16'h014f);
        u_rdr.pulse_nak();
        st(tsm_pkg::ST_IDLE);
        u_rdr.send(8'h26, 8'h00, 4'h8);
        u_rdr.send(8'h30, 8'h00, 4'h0);
        u_rdr.send(8'h26, 8'h00, 4'h8);
        st(tsm_pkg::ST_IDLE);
        chk("err2", 16'(cmdError), 16'h0001);
        u_rdr.send(8'h26, 8'h00, 4'h8);
        u_rdr.send(8'h30, 8'h00, 4'h0);
        u_rdr.send(8'h50, 8'h00, 4'h2);
        st(tsm_pkg::ST_IDLE);
        rsp(16'h8002);
        u_rdr.send(8'h26, 8'h00, 4'h8);
        u_rdr.send(8'h60, 8'h00, 4'h0);
        st(tsm_pkg::ST_IDLE);
        chk("err3", {memV, 14'h0000, cmdError}, 16'h0001);
        u_rdr.send(8'h26, 8'h00, 4'h8);
        u_rdr.send(8'h93, 8'h70, 4'h0);
        u_rdr.send(8'h93, 8'h70, 4'h0);
        st(tsm_pkg::ST_IDLE);
        chk("err4", 16'(cmdError), 16'h0001);
    endtask : t_active
    task automatic t_field;
        field = 1'b0;
        repeat (3) @(negedge clk);
        st(tsm_pkg::ST_OFF);
    endtask : t_field
    task automatic report_and_stop;
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #4000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        {rst, en, field} = 3'h4;
        repeat (2) @(negedge clk);
        {rst, en, field} = 3'h3;
        repeat (4) @(negedge clk);
        st(tsm_pkg::ST_IDLE);
        t_idle();
        t_select();
        t_halt();
        t_read();
        t_lost();
        t_anticoll();
        t_active();
        t_field();
        report_and_stop();
    end
endmodule : test_tsm_tag_fsm
`default_nettype wire
